// ===== common/ckdiv_consts.svh
// Offsets, field positions, reset values and timing counts for the clock divider control block.
// Assumes a 40 MHz system clock; included by bare name.
`ifndef CKDIV_CONSTS_SVH
`define CKDIV_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CKDIV_OFF_SPREAD_HI       8'h12
`define CKDIV_OFF_DIV_SEL         8'h13
`define CKDIV_OFF_LINK_SEL        8'h14

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CKDIV_SPREAD_HI_MASK      8'h7F
`define CKDIV_LINK_SEL_MASK       8'h0F
`define CKDIV_SPREAD_HI_RST       8'h00
`define CKDIV_DIV_SEL_RST         8'h00
`define CKDIV_LINK_SEL_RST        8'h00
`define CKDIV_PROC_MSB            7
`define CKDIV_PROC_LSB            4
`define CKDIV_GFX_MSB             3
`define CKDIV_GFX_LSB             0
`define CKDIV_STRAP_W             5

// ----------------------------------------
// Timing
// ----------------------------------------
`define CKDIV_CLK_MHZ             40
`define CKDIV_CONFIRM_CYC         2
`define CKDIV_STOP_NS             3000
`define CKDIV_STOP_CYC            ((`CKDIV_STOP_NS * `CKDIV_CLK_MHZ) / 1000)
`define CKDIV_RESTART_US          2500
`define CKDIV_RESTART_CYC         (`CKDIV_RESTART_US * `CKDIV_CLK_MHZ)
`define CKDIV_PWROFF_CYC          16
`define CKDIV_DEBOUNCE_CYC        4

`endif

// ===== common/ckdiv_pkg.sv
// Types for the clock divider control block.
// Assumes nothing beyond the consts header.
package ckdiv_pkg;
   typedef enum logic [2:0] {
      CKDIV_RUN,
      CKDIV_CONFIRM,
      CKDIV_STOP,
      CKDIV_PWROFF,
      CKDIV_RESTART
   } ckdiv_seq_t;
endpackage

// ===== src/ckdiv_debounce.sv
// Synchroniser and debouncer for the active-low reset pin.
// Assumes the pin is asynchronous to clock.
`timescale 1ns/1ps
`include "ckdiv_consts.svh"
module ckdiv_debounce (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic clk_en,
   input  wire logic pin_in,
   output logic      level_ff
);
   logic       sync1_ff;
   logic       sync2_ff;
   logic [2:0] cnt_ff;
   logic       nxt_level;
   logic [2:0] nxt_cnt;

   // ----------------------------------------
   // Hysteresis: level flips only after a stable run
   // ----------------------------------------
   always_comb begin
      nxt_level = level_ff;
      nxt_cnt   = 3'h0;
      if (sync2_ff != level_ff) begin
         if (cnt_ff == 3'(`CKDIV_DEBOUNCE_CYC - 1)) begin
            nxt_level = sync2_ff;
         end else begin
            nxt_cnt = cnt_ff + 3'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
         level_ff <= 1'b1;
         cnt_ff   <= 3'h0;
      end else if (clk_en) begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
         level_ff <= nxt_level;
         cnt_ff   <= nxt_cnt;
      end
   end
endmodule // ckdiv_debounce

// ===== src/ckdiv_ctrl.sv
// Control logic of a multi-output clock generator: divider select bytes,
// spread high byte, reset-pin sequencing and strap latching.
// Assumes a byte-wide management access port from the bus engine and a 40 MHz clock.
`timescale 1ns/1ps
`include "ckdiv_consts.svh"
module ckdiv_ctrl #(
   parameter int unsigned  RESTART_CYC = `CKDIV_RESTART_CYC,
   parameter logic [127:0] PROC_LUT    = 128'h0F0E0D0C0B0A09080706050403020100,
   parameter logic [127:0] GFX_LUT     = 128'h0F0E0D0C0B0A09080706050403020100,
   parameter logic [127:0] LINK_LUT    = 128'h0F0E0D0C0B0A09080706050403020100
) (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   input  wire logic       reset_in_n,
   input  wire logic       cfg_wr,
   input  wire logic       cfg_rd,
   input  wire logic [7:0] cfg_addr,
   input  wire logic [7:0] cfg_wdata,
   output logic [7:0]      cfg_rdata,
   input  wire logic [4:0] strap_in,
   output logic [4:0]      strap_out,
   output logic [4:0]      strap_oe_n,
   input  wire logic [4:0] strap_clk,
   output logic [4:0]      strap_val,
   output logic            outputs_run,
   output logic            ref_run,
   output logic            pll_power,
   output logic            seq_busy,
   output logic [7:0]      proc_ratio,
   output logic [7:0]      gfx_ratio,
   output logic [7:0]      link_ratio,
   output logic [6:0]      gfx_spread_hi
);
   localparam int unsigned STOP_CYC = `CKDIV_STOP_CYC;

   // ----------------------------------------
   // Reset pin conditioning
   // ----------------------------------------
   logic rst_lvl;
   ckdiv_debounce u_deb (
      .clock    (clock),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .pin_in   (reset_in_n),
      .level_ff (rst_lvl)
   );

   logic prev_lvl_ff;
   logic fall;
   assign fall = prev_lvl_ff & ~rst_lvl;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   ckdiv_pkg::ckdiv_seq_t state_ff;
   ckdiv_pkg::ckdiv_seq_t nxt_state;
   logic [16:0]           cnt_ff;
   logic [16:0]           nxt_cnt;
   logic                  reload;
   logic                  run_ff;
   logic                  nxt_run;
   logic                  pwr_ff;
   logic                  nxt_pwr;
   logic                  strap_done_ff;
   logic [1:0]            sync_full_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff + 17'h1;
      nxt_run   = run_ff;
      nxt_pwr   = pwr_ff;
      reload    = 1'b0;
      case (state_ff)
         ckdiv_pkg::CKDIV_RUN: begin
            nxt_cnt = 17'h0;
            if (fall) begin
               nxt_state = ckdiv_pkg::CKDIV_CONFIRM;
            end else if (strap_done_ff) begin
               nxt_run = 1'b1;
            end
         end
         ckdiv_pkg::CKDIV_CONFIRM: begin
            if (rst_lvl) begin
               nxt_state = ckdiv_pkg::CKDIV_RUN;
               nxt_cnt   = 17'h0;
            end else if (cnt_ff == 17'(`CKDIV_CONFIRM_CYC - 1)) begin
               nxt_state = ckdiv_pkg::CKDIV_STOP;
               nxt_cnt   = 17'h0;
            end
         end
         ckdiv_pkg::CKDIV_STOP: begin
            // Gate at the next cycle boundary; outputs held low, never cut mid-pulse
            nxt_run = 1'b0;
            if (cnt_ff == 17'(STOP_CYC - 1)) begin
               nxt_state = ckdiv_pkg::CKDIV_PWROFF;
               nxt_cnt   = 17'h0;
               nxt_pwr   = 1'b0;
            end
         end
         ckdiv_pkg::CKDIV_PWROFF: begin
            reload = 1'b1;
            if (cnt_ff == 17'(`CKDIV_PWROFF_CYC - 1)) begin
               nxt_state = ckdiv_pkg::CKDIV_RESTART;
               nxt_cnt   = 17'h0;
               nxt_pwr   = 1'b1;
            end
         end
         ckdiv_pkg::CKDIV_RESTART: begin
            // Restart waits the full lock budget so the first edge is clean
            if (cnt_ff == 17'(RESTART_CYC - 1)) begin
               nxt_state = ckdiv_pkg::CKDIV_RUN;
               nxt_cnt   = 17'h0;
               nxt_run   = 1'b1;
            end
         end
         default: begin
            nxt_state = ckdiv_pkg::CKDIV_RUN;
            nxt_cnt   = 17'h0;
            nxt_run   = 1'b1;
            nxt_pwr   = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_ff    <= ckdiv_pkg::CKDIV_RUN;
         cnt_ff      <= 17'h0;
         run_ff      <= 1'b0;
         pwr_ff      <= 1'b1;
         prev_lvl_ff <= 1'b1;
      end else if (clk_en) begin
         state_ff    <= nxt_state;
         cnt_ff      <= nxt_cnt;
         run_ff      <= nxt_run;
         pwr_ff      <= nxt_pwr;
         prev_lvl_ff <= rst_lvl;
      end
   end

   // ----------------------------------------
   // Strap latch and shared pins
   // ----------------------------------------
   logic [4:0] strap_s1_ff;
   logic [4:0] strap_s2_ff;
   logic [4:0] strap_ff;
   logic [4:0] nxt_strap;
   logic       nxt_done;

   always_comb begin
      nxt_strap = strap_ff;
      nxt_done  = sync_full_ff[1];
      if (!strap_done_ff) begin
         nxt_strap = strap_s2_ff;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         strap_s1_ff   <= 5'h00;
         strap_s2_ff   <= 5'h00;
         strap_ff      <= 5'h00;
         strap_done_ff <= 1'b0;
      end else if (clk_en) begin
         strap_s1_ff   <= strap_in;
         strap_s2_ff   <= strap_s1_ff;
         strap_ff      <= nxt_strap;
         strap_done_ff <= nxt_done;
      end
   end

   // Latch closes only once both synchroniser stages hold real pin levels
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync_full_ff <= 2'h0;
      end else if (clk_en) begin
         sync_full_ff <= {sync_full_ff[0], 1'b1};
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `CKDIV_STRAP_W; gi++) begin : g_strap
         // Pins float as inputs until the latch closes, then drive clocks
         assign strap_oe_n[gi] = ~strap_done_ff;
         assign strap_out[gi]  = strap_done_ff & strap_clk[gi];
      end
   endgenerate

   // ----------------------------------------
   // Configuration bytes
   // ----------------------------------------
   logic [7:0] spread_ff;
   logic [7:0] div_ff;
   logic [7:0] link_ff;
   logic [7:0] nxt_spread;
   logic [7:0] nxt_div;
   logic [7:0] nxt_link;
   logic [7:0] nxt_rdata;
   logic [7:0] rdata_ff;

   always_comb begin
      nxt_spread = spread_ff;
      nxt_div    = div_ff;
      nxt_link   = link_ff;
      if (reload) begin
         nxt_spread = `CKDIV_SPREAD_HI_RST;
         nxt_div    = `CKDIV_DIV_SEL_RST;
         nxt_link   = `CKDIV_LINK_SEL_RST;
      end else if (cfg_wr) begin
         case (cfg_addr)
            `CKDIV_OFF_SPREAD_HI: nxt_spread = cfg_wdata & `CKDIV_SPREAD_HI_MASK;
            `CKDIV_OFF_DIV_SEL:   nxt_div    = cfg_wdata;
            `CKDIV_OFF_LINK_SEL:  nxt_link   = cfg_wdata & `CKDIV_LINK_SEL_MASK;
            default: begin
            end
         endcase
      end
      nxt_rdata = rdata_ff;
      if (cfg_rd) begin
         case (cfg_addr)
            `CKDIV_OFF_SPREAD_HI: nxt_rdata = spread_ff;
            `CKDIV_OFF_DIV_SEL:   nxt_rdata = div_ff;
            `CKDIV_OFF_LINK_SEL:  nxt_rdata = link_ff;
            default:              nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         spread_ff <= `CKDIV_SPREAD_HI_RST;
         div_ff    <= `CKDIV_DIV_SEL_RST;
         link_ff   <= `CKDIV_LINK_SEL_RST;
         rdata_ff  <= 8'h00;
      end else if (clk_en) begin
         spread_ff <= nxt_spread;
         div_ff    <= nxt_div;
         link_ff   <= nxt_link;
         rdata_ff  <= nxt_rdata;
      end
   end

   // ----------------------------------------
   // Ratio decode, registered
   // ----------------------------------------
   logic [7:0] proc_ff;
   logic [7:0] gfx_ff;
   logic [7:0] lnk_ff;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         proc_ff <= 8'h00;
         gfx_ff  <= 8'h00;
         lnk_ff  <= 8'h00;
      end else if (clk_en) begin
         proc_ff <= PROC_LUT[div_ff[`CKDIV_PROC_MSB:`CKDIV_PROC_LSB]*8 +: 8];
         gfx_ff  <= GFX_LUT[div_ff[`CKDIV_GFX_MSB:`CKDIV_GFX_LSB]*8 +: 8];
         lnk_ff  <= LINK_LUT[link_ff[3:0]*8 +: 8];
      end
   end

   assign cfg_rdata     = rdata_ff;
   assign strap_val     = strap_ff;
   assign outputs_run   = run_ff;
   assign ref_run       = 1'b1;
   assign pll_power     = pwr_ff;
   assign seq_busy      = (state_ff != ckdiv_pkg::CKDIV_RUN);
   assign proc_ratio    = proc_ff;
   assign gfx_ratio     = gfx_ff;
   assign link_ratio    = lnk_ff;
   assign gfx_spread_hi = spread_ff[6:0];
endmodule // ckdiv_ctrl

// ===== verification/ckdiv_ctrl_checker.sv
// Checker for ckdiv_ctrl: reset pin sequencing, reserved fields, strap pins.
// Assumes it sees only the ports of ckdiv_ctrl, bound below.
`timescale 1ns/1ps
module ckdiv_ctrl_checker #(
   parameter int unsigned RESTART_CYC = 50
) (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic       clk_en,
   input wire logic       reset_in_n,
   input wire logic       cfg_wr,
   input wire logic       cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   input wire logic [7:0] cfg_rdata,
   input wire logic [4:0] strap_in,
   input wire logic [4:0] strap_out,
   input wire logic [4:0] strap_oe_n,
   input wire logic [4:0] strap_clk,
   input wire logic [4:0] strap_val,
   input wire logic       outputs_run,
   input wire logic       ref_run,
   input wire logic       pll_power,
   input wire logic       seq_busy,
   input wire logic [7:0] proc_ratio,
   input wire logic [7:0] gfx_ratio,
   input wire logic [7:0] link_ratio,
   input wire logic [6:0] gfx_spread_hi
);
   // ---------
   // Helpers
   // ---------
   // Slack covers the stop and power-off intervals; a frozen clk_en would stretch this
   localparam int unsigned STOP_MAX = RESTART_CYC + 160;
   int unsigned cnt_ff;
   int unsigned nxt_cnt;
   always_comb nxt_cnt = outputs_run ? 0 : cnt_ff + 1;
   always_ff @(posedge clock) cnt_ff <= rst_n ? nxt_cnt : 0;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ---------
   // Properties
   // ---------
   property p_ref_run; ref_run; endproperty
   a_ref_run: assert property (p_ref_run) else $error("reference clocks stopped");
   property p_link_rsvd; cfg_rd && clk_en && cfg_addr == 8'h14 |=> cfg_rdata[7:4] == 4'h0; endproperty
   a_link_rsvd: assert property (p_link_rsvd) else $error("link byte upper nibble not zero");
   property p_stop;
      disable iff (!rst_n || !clk_en) $fell(reset_in_n) ##1 !reset_in_n [*8] |-> ##[0:121] !outputs_run;
   endproperty
   a_stop: assert property (p_stop) else $error("outputs not stopped in time");
   property p_glitch;
      disable iff (!rst_n || !clk_en)
      outputs_run && !seq_busy ##0 $fell(reset_in_n) ##2 $rose(reset_in_n) |-> outputs_run [*8];
   endproperty
   a_glitch: assert property (p_glitch) else $error("short pin pulse acted on");
   property p_pwroff; $fell(pll_power) |-> (!pll_power && !outputs_run) [*8]; endproperty
   a_pwroff: assert property (p_pwroff) else $error("power-off too short");
   property p_reload; $rose(pll_power) |-> gfx_spread_hi == 7'h00; endproperty
   a_reload: assert property (p_reload) else $error("spread byte not reloaded");
   property p_restart; cnt_ff <= STOP_MAX; endproperty
   a_restart: assert property (p_restart) else $error("outputs stopped too long");
   property p_no_rise; $rose(reset_in_n) && outputs_run && !seq_busy |-> outputs_run [*8]; endproperty
   a_no_rise: assert property (p_no_rise) else $error("pin release acted on");
   property p_strap_drive; $rose(rst_n) |-> ##[1:6] strap_oe_n == 5'h00; endproperty
   a_strap_drive: assert property (p_strap_drive) else $error("strap pins not driven");
   property p_strap_hold; strap_oe_n == 5'h00 |=> $stable(strap_val); endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap latch changed");
   property p_strap_sample; $fell(strap_oe_n[0]) |-> strap_val == $past(strap_in); endproperty
   a_strap_sample: assert property (p_strap_sample) else $error("strap levels not latched");
   c_seq: cover property ($fell(pll_power));
   c_glitch: cover property ($fell(reset_in_n) ##2 $rose(reset_in_n));
   c_rd: cover property (cfg_rd && cfg_addr == 8'h13);
endmodule // ckdiv_ctrl_checker

bind ckdiv_ctrl ckdiv_ctrl_checker #(.RESTART_CYC(RESTART_CYC)) i_chk (
   .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .reset_in_n(reset_in_n), .cfg_wr(cfg_wr),
   .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
   .strap_in(strap_in), .strap_out(strap_out), .strap_oe_n(strap_oe_n), .strap_clk(strap_clk),
   .strap_val(strap_val), .outputs_run(outputs_run), .ref_run(ref_run), .pll_power(pll_power),
   .seq_busy(seq_busy), .proc_ratio(proc_ratio), .gfx_ratio(gfx_ratio), .link_ratio(link_ratio),
   .gfx_spread_hi(gfx_spread_hi));

// ===== verification/ckdiv_board.sv
// Board model: strap pulls on the shared pins and the reset push-button.
// Assumes a strap pin is released while its enable is high.
`timescale 1ns/1ps
module ckdiv_board #(
   parameter logic [4:0] PULLS = 5'h16
) (
   input wire logic       clock,
   input wire logic [4:0] strap_out,
   input wire logic [4:0] strap_oe_n,
   output logic [4:0]     strap_in,
   output logic           reset_in_n
);
   initial reset_in_n = 1'b1;
   // Released pins fall back to the pull, never a stale clock level
   assign strap_in = (~strap_oe_n & strap_out) | (strap_oe_n & PULLS);
   task automatic set_pin(input logic lvl, input int hold);
      reset_in_n = lvl;
      repeat (hold) @(negedge clock);
   endtask
endmodule // ckdiv_board

// ===== verification/clock_divider_cfg_and_reset_seq_test.sv
// Self-checking bench for ckdiv_ctrl: register port, reset pin sequence, straps.
// Assumes a 40 MHz clock and a shortened restart count.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
   $display("FAIL %0t act=%h exp=%h", $time, a, e); end end
module clock_divider_cfg_and_reset_seq_test;
   localparam int unsigned RESTART = 50;
   localparam logic [4:0]  PULLS   = 5'h16;
   logic       clock, rst_n, clk_en, cfg_wr, cfg_rd, outputs_run, ref_run, pll_power, seq_busy, reset_in_n;
   logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, proc_ratio, gfx_ratio, link_ratio;
   logic [4:0] strap_in, strap_out, strap_oe_n, strap_clk, strap_val;
   logic [6:0] gfx_spread_hi;
   int         n_mismatch = 0;
   int         checks     = 0;
   int         n;
   ckdiv_ctrl #(.RESTART_CYC(RESTART)) i_dut (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .reset_in_n(reset_in_n), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .strap_in(strap_in), .strap_out(strap_out), .strap_oe_n(strap_oe_n), .strap_clk(strap_clk),
      .strap_val(strap_val), .outputs_run(outputs_run), .ref_run(ref_run), .pll_power(pll_power),
      .seq_busy(seq_busy), .proc_ratio(proc_ratio), .gfx_ratio(gfx_ratio), .link_ratio(link_ratio),
      .gfx_spread_hi(gfx_spread_hi));
   ckdiv_board #(.PULLS(PULLS)) i_board (
      .clock(clock), .strap_out(strap_out), .strap_oe_n(strap_oe_n), .strap_in(strap_in),
      .reset_in_n(reset_in_n));
   // ---------
   // Tasks
   // ---------
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      cfg_addr  = a;
      cfg_wdata = d;
      cfg_wr    = 1'b1;
      @(negedge clock);
      cfg_wr    = 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(negedge clock);
      cfg_addr = a;
      cfg_rd   = 1'b1;
      @(negedge clock);
      cfg_rd   = 1'b0;
      `CHK(cfg_rdata, e)
   endtask
   // Bounded wait on outputs_run, or on pll_power when pll is set
   task automatic wait_for(input logic pll, input logic lvl, input int max, output int cnt);
      cnt = 0;
      while (((pll ? pll_power : outputs_run) !== lvl) && cnt < max) begin
         @(negedge clock);
         cnt++;
      end
      if (cnt >= max) begin
         n_mismatch++;
         stop_test();
      end
   endtask
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // ---------
   // Sequence
   // ---------
   initial begin
      rst_n     = 1'b0;
      clk_en    = 1'b1;
      cfg_wr    = 1'b0;
      cfg_rd    = 1'b0;
      cfg_addr  = 8'h00;
      cfg_wdata = 8'h00;
      strap_clk = 5'h0A;
      repeat (12) @(negedge clock);
      rst_n = 1'b1;
      repeat (8) @(negedge clock);
      rd_chk(8'h12, 8'h00);
      rd_chk(8'h13, 8'h00);
      rd_chk(8'h14, 8'h00);
      `CHK(strap_val, PULLS)
      `CHK(strap_in, strap_clk)
      $display("test reset_values done");
      wr(8'h13, 8'hA5);
      wr(8'h14, 8'hFF);
      wr(8'h12, 8'hFF);
      wr(8'h15, 8'h3C);
      rd_chk(8'h13, 8'hA5);
      rd_chk(8'h14, 8'h0F);
      rd_chk(8'h12, 8'h7F);
      rd_chk(8'h15, 8'h00);
      `CHK({proc_ratio, gfx_ratio, link_ratio, 1'b0, gfx_spread_hi}, 32'h0A050F7F)
      // Writes while frozen must be lost
      clk_en = 1'b0;
      wr(8'h13, 8'h11);
      clk_en = 1'b1;
      rd_chk(8'h13, 8'hA5);
      $display("test fields done");
      i_board.set_pin(1'b0, 2);
      i_board.set_pin(1'b1, 20);
      `CHK(outputs_run, 1'b1)
      $display("test glitch done");
      i_board.set_pin(1'b0, 0);
      wait_for(1'b0, 1'b0, 40, n);
      `CHK(n >= 3, 1'b1)
      `CHK(seq_busy, 1'b1)
      `CHK(ref_run, 1'b1)
      wait_for(1'b1, 1'b0, 200, n);
      `CHK(n <= 121, 1'b1)
      wait_for(1'b1, 1'b1, 40, n);
      rd_chk(8'h13, 8'h00);
      wait_for(1'b0, 1'b1, RESTART + 10, n);
      `CHK(n <= RESTART, 1'b1)
      `CHK(seq_busy, 1'b0)
      $display("test sequence done");
      wr(8'h14, 8'h03);
      i_board.set_pin(1'b1, 30);
      `CHK(outputs_run, 1'b1)
      rd_chk(8'h14, 8'h03);
      `CHK(strap_val, PULLS)
      $display("test release done");
      stop_test();
   end
endmodule // clock_divider_cfg_and_reset_seq_test
